// *** rtl/vrsc_defines.svh ***
`ifndef VRSC_DEFINES_SVH
`define VRSC_DEFINES_SVH
// command word: control bits low, start row above
`define VRSC_CMD_W 16
`define VRSC_ADDR_W 11
`define VRSC_ADDR_LSB 5
`define VRSC_C_CUE 0
`define VRSC_C_IGN 1
`define VRSC_C_PWR 2
`define VRSC_C_PLAY 3
`define VRSC_C_RUN 4
// status word: overflow, end of message, row pointer
`define VRSC_STAT_W 13
`define VRSC_S_OVF 0
`define VRSC_S_EOM 1
`define VRSC_S_PTR_LSB 2
// control codes, bit n is control bit n
`define VRSC_CODE_WAKE 5'h04
`define VRSC_CODE_SOUND_AT 5'h1c
`define VRSC_CODE_SOUND_HERE 5'h1e
`define VRSC_CODE_CAPTURE_AT 5'h14
`define VRSC_CODE_CAPTURE_HERE 5'h16
`define VRSC_CODE_SKIP_AT 5'h1d
`define VRSC_CODE_SKIP_HERE 5'h1f
`define VRSC_CODE_HALT 5'h06
`define VRSC_MASK_HALT 5'h17
`define VRSC_CODE_HALT_SLEEP 5'h02
`define VRSC_MASK_HALT_SLEEP 5'h16
// timing, clock in kHz so products stay below 2**31
`define VRSC_CLK_KHZ 125000
`define VRSC_T_PUD_MS 25
`define VRSC_T_STOP_MS 50
`define VRSC_T_ROW_MS 200
`define VRSC_CUE_SPEEDUP 1600
`define VRSC_ROWS 2048
`define VRSC_SCLK_HALF 8
// host register map, byte addresses
`define VRSC_REG_CMD 4'h0
`define VRSC_REG_STATUS 4'h4
`define VRSC_REG_IRQ_STAT 4'h8
`define VRSC_REG_IRQ_MASK 4'hc
`define VRSC_IRQ_XFER 0
`define VRSC_IRQ_DEV 1
`endif

// *** rtl/vrsc_device.sv ***
`timescale 1ns/1ns
module vrsc_device
  import vrsc_pkg::*;
#(
  parameter int ROWS = `VRSC_ROWS,
  parameter int ROW_CYCLES = `VRSC_T_ROW_MS * `VRSC_CLK_KHZ,
  parameter int PUD_CYCLES = `VRSC_T_PUD_MS * `VRSC_CLK_KHZ
)(
  input wire logic clk_sys_in,
  input wire logic srst_in,
  vrsc_spi_if.dev spi,
  output vrsc_op_t op_out,
  output logic ready_out,
  output logic [`VRSC_ADDR_W-1:0] row_pointer_out
);
  localparam int CUE_CYCLES = ROW_CYCLES / `VRSC_CUE_SPEEDUP;
  localparam int CW = $clog2(ROW_CYCLES + 1);
  localparam int PW = $clog2(PUD_CYCLES + 1);
  localparam int AW = `VRSC_ADDR_W;

  if (ROWS > 2 ** AW || ROWS < 2 || CUE_CYCLES < 8 || PUD_CYCLES < 1)
  begin : g_bad
    $error("vrsc_device: unsupported parameters");
  end

  // ***********************************
  // pin synchronisers and edges
  // ***********************************
  logic [1:0] sclk_sync_reg;
  logic [1:0] ss_sync_reg;
  logic [1:0] mosi_sync_reg;
  logic sclk_prev_reg;
  logic ss_prev_reg;
  // link pins come from the host clock world, two flops each
  always_ff @(posedge clk_sys_in)
  begin
    if (srst_in)
    begin
      sclk_sync_reg <= 2'h0;
      ss_sync_reg <= 2'h3;
      mosi_sync_reg <= 2'h0;
      sclk_prev_reg <= 1'b0;
      ss_prev_reg <= 1'b1;
    end
    else
    begin
      sclk_sync_reg <= {sclk_sync_reg[0], spi.sclk};
      ss_sync_reg <= {ss_sync_reg[0], spi.ss_n};
      mosi_sync_reg <= {mosi_sync_reg[0], spi.mosi};
      sclk_prev_reg <= sclk_sync_reg[1];
      ss_prev_reg <= ss_sync_reg[1];
    end
  end

  logic sel;
  logic sclk_rise;
  logic sclk_fall;
  logic ss_fall;
  logic ss_rise;
  // serial clock edges only count while selected
  assign sel = ~ss_sync_reg[1];
  assign sclk_rise = sel & sclk_sync_reg[1] & ~sclk_prev_reg;
  assign sclk_fall = sel & ~sclk_sync_reg[1] & sclk_prev_reg;
  assign ss_fall = sel & ss_prev_reg;
  assign ss_rise = ~sel & ~ss_prev_reg;

  // ***********************************
  // serial shift registers
  // ***********************************
  logic [`VRSC_CMD_W-1:0] in_reg;
  logic [4:0] bit_cnt_reg;
  logic [`VRSC_STAT_W-1:0] out_reg;
  logic eom_flag_reg;
  logic ovf_flag_reg;
  logic [AW-1:0] ptr_reg;
  // command bits enter lsb first on rising clock
  always_ff @(posedge clk_sys_in)
  begin
    if (srst_in)
    begin
      in_reg <= 16'h0000;
      bit_cnt_reg <= 5'h00;
    end
    else if (ss_fall)
      bit_cnt_reg <= 5'h00;
    else if (sclk_rise)
    begin
      in_reg <= {mosi_sync_reg[1], in_reg[`VRSC_CMD_W-1:1]};
      if (bit_cnt_reg != 5'h10)
        bit_cnt_reg <= bit_cnt_reg + 5'h01;
    end
  end

  // status is snapshot at select fall, then advanced on falling clock
  always_ff @(posedge clk_sys_in)
  begin
    if (srst_in)
      out_reg <= 13'h0000;
    else if (ss_fall)
      out_reg <= {ptr_reg, eom_flag_reg, ovf_flag_reg};
    else if (sclk_fall)
      out_reg <= {1'b0, out_reg[`VRSC_STAT_W-1:1]};
  end

  assign spi.miso_o = out_reg[0];
  assign spi.miso_oe = sel;

  // ***********************************
  // command decode
  // ***********************************
  logic cmd_done;
  logic [4:0] ctl;
  logic [AW-1:0] addr;
  logic pwr_reg;
  logic ready_reg;
  logic [PW-1:0] pud_cnt_reg;
  logic start;
  logic stop;
  // partial words are dropped; nothing acts before select rises
  assign cmd_done = ss_rise & (bit_cnt_reg == 5'h10);
  assign ctl = in_reg[4:0];
  assign addr = in_reg[`VRSC_CMD_W-1:`VRSC_ADDR_LSB];
  // control bits decoded by meaning, covering every listed code
  assign start = cmd_done & ctl[`VRSC_C_PWR] & ctl[`VRSC_C_RUN] & ready_reg;
  assign stop = cmd_done & ~(ctl[`VRSC_C_PWR] & ctl[`VRSC_C_RUN]);

  // power control and wake delay
  always_ff @(posedge clk_sys_in)
  begin
    if (srst_in)
    begin
      pwr_reg <= 1'b0;
      ready_reg <= 1'b0;
      pud_cnt_reg <= '0;
    end
    else if (cmd_done & ~ctl[`VRSC_C_PWR])
    begin
      pwr_reg <= 1'b0;
      ready_reg <= 1'b0;
    end
    else if (cmd_done & ~pwr_reg)
    begin
      pwr_reg <= 1'b1;
      pud_cnt_reg <= PW'(PUD_CYCLES - 1);
    end
    else if (pwr_reg & ~ready_reg)
    begin
      if (pud_cnt_reg == '0)
        ready_reg <= 1'b1;
      else
        pud_cnt_reg <= pud_cnt_reg - PW'(1);
    end
  end

  // ***********************************
  // row engine
  // ***********************************
  vrsc_op_t op_reg;
  vrsc_op_t new_op;
  logic [CW-1:0] row_cnt_reg;
  logic repeat_reg;
  logic mark_reg [ROWS];
  logic row_end;
  logic row_go;
  logic at_last;
  logic eom_hit;
  logic [AW-1:0] first_row;

  function automatic logic [CW-1:0] row_load(input vrsc_op_t op);
    row_load = (op == VRSC_OP_CUE) ? CW'(CUE_CYCLES - 1) : CW'(ROW_CYCLES - 1);
  endfunction

  // cue only at the start of a playback
  assign new_op = ~ctl[`VRSC_C_PLAY] ? VRSC_OP_REC :
    ctl[`VRSC_C_CUE] ? VRSC_OP_CUE : VRSC_OP_PLAY;
  assign first_row = ctl[`VRSC_C_IGN] ? ptr_reg : addr;
  assign row_end = (op_reg != VRSC_OP_IDLE) & (row_cnt_reg == '0);
  assign row_go = row_end & ~start & ~stop;
  assign at_last = ptr_reg == AW'(ROWS - 1);
  assign eom_hit = (op_reg != VRSC_OP_REC) & mark_reg[ptr_reg];

  // a run command with the ignore bit while busy only ends row repeat
  always_ff @(posedge clk_sys_in)
  begin
    if (srst_in)
    begin
      op_reg <= VRSC_OP_IDLE;
      ptr_reg <= '0;
      row_cnt_reg <= '0;
      repeat_reg <= 1'b0;
    end
    else if (start & (op_reg != VRSC_OP_IDLE) & ctl[`VRSC_C_IGN])
    begin
      repeat_reg <= 1'b0;
      row_cnt_reg <= row_cnt_reg - CW'(1);
    end
    else if (start)
    begin
      op_reg <= new_op;
      ptr_reg <= first_row;
      repeat_reg <= ~ctl[`VRSC_C_IGN];
      row_cnt_reg <= row_load(new_op);
    end
    else if (stop)
      op_reg <= VRSC_OP_IDLE;
    else if (row_go)
    begin
      row_cnt_reg <= row_load(op_reg);
      if (eom_hit)
        op_reg <= VRSC_OP_IDLE;
      else if (at_last & ~repeat_reg)
        op_reg <= VRSC_OP_IDLE;
      if (~repeat_reg & ~at_last)
        ptr_reg <= ptr_reg + AW'(1);
    end
    else if (op_reg != VRSC_OP_IDLE)
      row_cnt_reg <= row_cnt_reg - CW'(1);
  end

  // message end markers; a halted recording marks its last row
  always_ff @(posedge clk_sys_in)
  begin
    if (srst_in)
    begin
      for (int i = 0; i < ROWS; i++)
        mark_reg[i] <= 1'b0;
    end
    else if (stop & (op_reg == VRSC_OP_REC))
      mark_reg[ptr_reg] <= 1'b1;
    else if (start & ~ctl[`VRSC_C_PLAY] & (op_reg == VRSC_OP_IDLE))
      mark_reg[first_row] <= 1'b0;
    else if (row_go & (op_reg == VRSC_OP_REC) & ~repeat_reg & ~at_last)
      mark_reg[ptr_reg + AW'(1)] <= 1'b0;
  end

  // ***********************************
  // interrupt flags
  // ***********************************
  // a new event wins over the clear at transfer start
  always_ff @(posedge clk_sys_in)
  begin
    if (srst_in)
    begin
      eom_flag_reg <= 1'b0;
      ovf_flag_reg <= 1'b0;
    end
    else
    begin
      if (row_go & eom_hit)
        eom_flag_reg <= 1'b1;
      else if (ss_fall)
        eom_flag_reg <= 1'b0;
      if (row_go & ~eom_hit & at_last & ~repeat_reg)
        ovf_flag_reg <= 1'b1;
      else if (ss_fall)
        ovf_flag_reg <= 1'b0;
    end
  end

  // open-drain request line, pulled low while a flag is pending
  assign spi.int_o = 1'b0;
  assign spi.int_oe = eom_flag_reg | ovf_flag_reg;

  // ***********************************
  // row clock and user outputs
  // ***********************************
  logic rac_reg;
  // row clock goes low for the last eighth of each row
  always_ff @(posedge clk_sys_in)
  begin
    if (srst_in)
      rac_reg <= 1'b1;
    else
      rac_reg <= (op_reg == VRSC_OP_IDLE) |
        (row_cnt_reg >= (row_load(op_reg) >> 3));
  end

  assign spi.row_address_clock = rac_reg;
  assign op_out = op_reg;
  assign ready_out = ready_reg;
  assign row_pointer_out = ptr_reg;
endmodule

// *** rtl/vrsc_host.sv ***
`timescale 1ns/1ns
module vrsc_host
  import vrsc_pkg::*;
#(
  parameter int SCLK_HALF = `VRSC_SCLK_HALF,
  parameter int PUD_CYCLES = `VRSC_T_PUD_MS * `VRSC_CLK_KHZ,
  parameter int STOP_CYCLES = `VRSC_T_STOP_MS * `VRSC_CLK_KHZ
)(
  input wire logic clk_sys_in,
  input wire logic srst_in,
  input wire logic [3:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  output logic irq_out,
  vrsc_spi_if.host spi
);
  localparam int HW = $clog2(SCLK_HALF + 1);
  localparam int TW = $clog2(2 * PUD_CYCLES + STOP_CYCLES + 1);

  // miso must settle through both synchronisers within half a clock
  if (SCLK_HALF < 6 || PUD_CYCLES < 1 || STOP_CYCLES < 1)
  begin : g_bad
    $error("vrsc_host: unsupported parameters");
  end

  // ***********************************
  // pin synchronisers
  // ***********************************
  logic [1:0] miso_sync_reg;
  logic [1:0] int_sync_reg;
  logic [1:0] rac_sync_reg;
  logic int_prev_reg;
  always_ff @(posedge clk_sys_in)
  begin
    if (srst_in)
    begin
      miso_sync_reg <= 2'h3;
      int_sync_reg <= 2'h3;
      rac_sync_reg <= 2'h3;
      int_prev_reg <= 1'b1;
    end
    else
    begin
      miso_sync_reg <= {miso_sync_reg[0], spi.miso};
      int_sync_reg <= {int_sync_reg[0], spi.int_n};
      rac_sync_reg <= {rac_sync_reg[0], spi.row_address_clock};
      int_prev_reg <= int_sync_reg[1];
    end
  end

  // ***********************************
  // serial engine
  // ***********************************
  vrsc_hst_t st_reg;
  logic [HW-1:0] half_reg;
  logic [TW-1:0] hold_reg;
  logic [`VRSC_CMD_W-1:0] tx_reg;
  logic [`VRSC_CMD_W-1:0] cmd_reg;
  logic [`VRSC_STAT_W-1:0] rx_reg;
  logic [3:0] bit_reg;
  logic wake_seen_reg;
  logic sclk_reg;
  logic ss_n_reg;
  logic mosi_reg;
  logic cmd_wr;
  logic half_done;
  logic xfer_done;
  logic [4:0] code;

  assign cmd_wr = avs_write_in & (avs_address_in == `VRSC_REG_CMD) & (st_reg == VRSC_H_IDLE);
  assign half_done = half_reg == '0;
  assign xfer_done = (st_reg == VRSC_H_DESEL) & half_done;
  assign code = cmd_reg[4:0];

  // bits leave lsb first on falling clock, status sampled on rising
  always_ff @(posedge clk_sys_in)
  begin
    if (srst_in)
    begin
      st_reg <= VRSC_H_IDLE;
      half_reg <= '0;
      hold_reg <= '0;
      tx_reg <= 16'h0000;
      cmd_reg <= 16'h0000;
      rx_reg <= 13'h0000;
      bit_reg <= 4'h0;
      wake_seen_reg <= 1'b0;
      sclk_reg <= 1'b0;
      ss_n_reg <= 1'b1;
      mosi_reg <= 1'b0;
    end
    else
    begin
      half_reg <= half_done ? HW'(SCLK_HALF - 1) : half_reg - HW'(1);
      case (st_reg)
        VRSC_H_IDLE:
          if (cmd_wr)
          begin
            tx_reg <= avs_writedata_in[15:0];
            cmd_reg <= avs_writedata_in[15:0];
            mosi_reg <= avs_writedata_in[0];
            ss_n_reg <= 1'b0;
            bit_reg <= 4'h0;
            half_reg <= HW'(SCLK_HALF - 1);
            st_reg <= VRSC_H_LOW;
          end
        VRSC_H_LOW:
          if (half_done)
          begin
            sclk_reg <= 1'b1;
            if (bit_reg < 4'hd)
              rx_reg <= {miso_sync_reg[1], rx_reg[`VRSC_STAT_W-1:1]};
            st_reg <= VRSC_H_HIGH;
          end
        VRSC_H_HIGH:
          if (half_done)
          begin
            sclk_reg <= 1'b0;
            tx_reg <= {1'b0, tx_reg[`VRSC_CMD_W-1:1]};
            mosi_reg <= tx_reg[1];
            bit_reg <= bit_reg + 4'h1;
            st_reg <= (bit_reg == 4'hf) ? VRSC_H_DESEL : VRSC_H_LOW;
          end
        VRSC_H_DESEL:
          if (half_done)
          begin
            ss_n_reg <= 1'b1;
            mosi_reg <= 1'b0;
            st_reg <= VRSC_H_HOLD;
            // pace the next command: wake delays, settle after halts
            if (vrsc_is_code(code, `VRSC_CODE_WAKE, 5'h1f))
            begin
              hold_reg <= wake_seen_reg ? TW'(2 * PUD_CYCLES) : TW'(PUD_CYCLES);
              wake_seen_reg <= 1'b1;
            end
            else if (vrsc_is_code(code, `VRSC_CODE_HALT_SLEEP, `VRSC_MASK_HALT_SLEEP))
            begin
              hold_reg <= TW'(STOP_CYCLES);
              wake_seen_reg <= 1'b0;
            end
            else if (vrsc_is_code(code, `VRSC_CODE_HALT, `VRSC_MASK_HALT))
              hold_reg <= TW'(STOP_CYCLES);
            else
              hold_reg <= TW'(1);
          end
        VRSC_H_HOLD:
          if (hold_reg == '0)
            st_reg <= VRSC_H_IDLE;
          else
            hold_reg <= hold_reg - TW'(1);
        default:
          st_reg <= VRSC_H_IDLE;
      endcase
    end
  end

  assign spi.sclk = sclk_reg;
  assign spi.ss_n = ss_n_reg;
  assign spi.mosi = mosi_reg;

  // ***********************************
  // register slave and interrupts
  // ***********************************
  logic [1:0] irq_stat_reg;
  logic [1:0] irq_mask_reg;
  logic rd_ack_reg;
  logic [31:0] rdata_reg;
  logic irq_reg;
  logic [1:0] ev;

  assign ev = {int_prev_reg & ~int_sync_reg[1], xfer_done};
  // reads take one wait cycle; command writes stall while busy
  assign avs_waitrequest_out = (avs_read_in & ~rd_ack_reg) |
    (avs_write_in & (avs_address_in == `VRSC_REG_CMD) & (st_reg != VRSC_H_IDLE));

  always_ff @(posedge clk_sys_in)
  begin
    if (srst_in)
    begin
      rd_ack_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
    end
    else
    begin
      rd_ack_reg <= avs_read_in & ~rd_ack_reg;
      case (avs_address_in)
        `VRSC_REG_CMD: rdata_reg <= {16'h0000, cmd_reg};
        `VRSC_REG_STATUS: rdata_reg <= {15'h0000, ~rac_sync_reg[1], st_reg == VRSC_H_HOLD,
          ~int_sync_reg[1], st_reg != VRSC_H_IDLE, rx_reg};
        `VRSC_REG_IRQ_STAT: rdata_reg <= {30'h0000_0000, irq_stat_reg};
        `VRSC_REG_IRQ_MASK: rdata_reg <= {30'h0000_0000, irq_mask_reg};
        default: rdata_reg <= 32'h0000_0000;
      endcase
    end
  end

  // sticky events, write one to clear, a new event wins
  always_ff @(posedge clk_sys_in)
  begin
    if (srst_in)
    begin
      irq_stat_reg <= 2'h0;
      irq_mask_reg <= 2'h0;
      irq_reg <= 1'b0;
    end
    else
    begin
      if (avs_write_in & (avs_address_in == `VRSC_REG_IRQ_STAT))
        irq_stat_reg <= (irq_stat_reg & ~avs_writedata_in[1:0]) | ev;
      else
        irq_stat_reg <= irq_stat_reg | ev;
      if (avs_write_in & (avs_address_in == `VRSC_REG_IRQ_MASK))
        irq_mask_reg <= avs_writedata_in[1:0];
      irq_reg <= |(irq_stat_reg & irq_mask_reg);
    end
  end

  assign avs_readdata_out = rdata_reg;
  assign irq_out = irq_reg;
endmodule

// *** rtl/vrsc_pkg.sv ***
`include "vrsc_defines.svh"
package vrsc_pkg;
  typedef enum logic [1:0] {VRSC_OP_IDLE, VRSC_OP_PLAY, VRSC_OP_REC, VRSC_OP_CUE} vrsc_op_t;
  typedef enum logic [2:0] {VRSC_H_IDLE, VRSC_H_LOW, VRSC_H_HIGH, VRSC_H_DESEL,
    VRSC_H_HOLD} vrsc_hst_t;
  // true when the control bits match a code in every bit the mask sets; clear mask bits are don't-care
  function automatic logic vrsc_is_code(input logic [4:0] c, input logic [4:0] code,
    input logic [4:0] mask);
    vrsc_is_code = ((c ^ code) & mask) == 5'h00;
  endfunction
endpackage

// *** rtl/vrsc_spi_if.sv ***
`timescale 1ns/1ns
interface vrsc_spi_if;
  logic sclk;
  logic ss_n;
  logic mosi;
  logic miso_o;
  logic miso_oe;
  logic int_o;
  logic int_oe;
  logic row_address_clock;
  logic miso;
  logic int_n;
  // idle line floats high through the pull-up
  assign miso = miso_oe ? miso_o : 1'b1;
  assign int_n = int_oe ? int_o : 1'b1;
  modport dev (input sclk, input ss_n, input mosi, output miso_o, output miso_oe,
    output int_o, output int_oe, output row_address_clock);
  modport host (output sclk, output ss_n, output mosi, input miso, input int_n,
    input row_address_clock);
endinterface

// *** tb/voice_recorder_spi_control_bench.sv ***
`timescale 1ns/1ns
module voice_recorder_spi_control_bench;
  import vrsc_pkg::*;
  `define CHK(got, exp) chk((got) === (exp))
  // ****************************************
  // signals and instances
  // ****************************************
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic [3:0] addr = 4'h0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic waitreq;
  logic irq;
  vrsc_op_t op;
  logic ready;
  logic [10:0] ptr;
  logic [31:0] r;
  logic irq_a;
  int failures = 0;
  int num_checks = 0;

  vrsc_spi_if spi();
  // short row and delay counts keep the run small
  vrsc_device #(.ROW_CYCLES(12800), .PUD_CYCLES(20)) vrsc_device_inst (
    .clk_sys_in(clk_sys), .srst_in(srst), .spi(spi), .op_out(op), .ready_out(ready),
    .row_pointer_out(ptr));
  vrsc_host #(.PUD_CYCLES(20), .STOP_CYCLES(40)) vrsc_host_inst (
    .clk_sys_in(clk_sys), .srst_in(srst), .avs_address_in(addr), .avs_read_in(rd),
    .avs_write_in(wr), .avs_writedata_in(wdata), .avs_readdata_out(rdata),
    .avs_waitrequest_out(waitreq), .irq_out(irq), .spi(spi));
  vrsc_spi_sva vrsc_spi_sva_inst (
    .clk_sys_in(clk_sys), .srst_in(srst), .sclk(spi.sclk), .ss_n(spi.ss_n),
    .mosi(spi.mosi), .miso_o(spi.miso_o), .miso_oe(spi.miso_oe), .int_o(spi.int_o),
    .int_oe(spi.int_oe), .row_address_clock(spi.row_address_clock), .miso(spi.miso), .int_n(spi.int_n));

  always #4 clk_sys = ~clk_sys;

  // ****************************************
  // tasks
  // ****************************************
  task automatic chk(input bit ok);
    num_checks++;
    if (!ok)
    begin
      failures++;
      $display("[FAIL] t=%0t value mismatch", $time);
    end
  endtask

  // one bus cycle; waitrequest is looked at just before the edge that takes it
  task automatic bus(input bit is_wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    addr <= a;
    wdata <= d;
    wr <= is_wr;
    rd <= !is_wr;
    @(negedge clk_sys);
    while (waitreq !== 1'b0)
      @(negedge clk_sys);
    r = rdata;
    @(posedge clk_sys);
    wr <= 1'b0;
    rd <= 1'b0;
  endtask

  // send a command and wait for the end of its frame
  task automatic cmd(input logic [4:0] code, input logic [10:0] row);
    bus(1'b1, `VRSC_REG_CMD, {16'h0000, row, code});
    repeat (2) @(posedge clk_sys);
    for (int i = 0; i < 4000 && spi.ss_n !== 1'b1; i++)
      @(posedge clk_sys);
  endtask

  // command, then poll busy; the device acts about 3 cycles after select rises
  task automatic run(input logic [4:0] code, input logic [10:0] row);
    cmd(code, row);
    bus(1'b0, `VRSC_REG_STATUS, 32'h0);
    for (int i = 0; i < 300 && r[13] !== 1'b0; i++)
      bus(1'b0, `VRSC_REG_STATUS, 32'h0);
    repeat (8) @(posedge clk_sys);
  endtask

  task automatic wait_int(input int n);
    for (int i = 0; i < n && spi.int_n !== 1'b0; i++)
      @(posedge clk_sys);
    `CHK(spi.int_n, 1'b0);
  endtask

  task automatic tend(input string s);
    $display("test %s done", s);
  endtask

  task automatic summarize();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // ****************************************
  // test sequence
  // ****************************************
  initial
  begin
    repeat (16) @(posedge clk_sys);
    srst <= 1'b0;
    bus(1'b0, `VRSC_REG_STATUS, 32'h0);
    `CHK(r, 32'h0000_0000);
    bus(1'b0, 4'h1, 32'h0);
    `CHK(r, 32'h0000_0000);
    `CHK(ready, 1'b0);
    `CHK(irq, 1'b0);
    tend("reset");
    // mask polarity is open: exactly one of the two settings must raise irq
    bus(1'b1, `VRSC_REG_IRQ_MASK, 32'h0);
    cmd(`VRSC_CODE_WAKE, 11'h000);
    repeat (8) @(posedge clk_sys);
    `CHK(ready, 1'b0);
    irq_a = irq;
    bus(1'b1, `VRSC_REG_IRQ_MASK, 32'h3);
    repeat (2) @(posedge clk_sys);
    `CHK(irq ^ irq_a, 1'b1);
    bus(1'b1, `VRSC_REG_IRQ_STAT, 32'h3);
    repeat (2) @(posedge clk_sys);
    `CHK(irq, 1'b0);
    run(`VRSC_CODE_WAKE, 11'h000);
    `CHK(ready, 1'b1);
    tend("wake");
    run(`VRSC_CODE_CAPTURE_AT, 11'd5);
    `CHK(op, VRSC_OP_REC);
    `CHK(ptr, 11'd5);
    run(`VRSC_CODE_HALT, 11'h000);
    `CHK(op, VRSC_OP_IDLE);
    tend("record");
    run(`VRSC_CODE_SKIP_HERE, 11'd300);
    `CHK(op, VRSC_OP_IDLE);
    `CHK(ptr, 11'd6);
    `CHK(spi.int_n, 1'b0);
    run(`VRSC_CODE_SKIP_HERE, 11'h000);
    `CHK(r[12:0], 13'h001a);
    `CHK(spi.int_n, 1'b1);
    wait_int(17000);
    `CHK(op, VRSC_OP_IDLE);
    tend("cue");
    run(`VRSC_CODE_SOUND_AT, 11'd5);
    `CHK(r[0], 1'b1);
    `CHK(op, VRSC_OP_PLAY);
    `CHK(ptr, 11'd5);
    run(`VRSC_CODE_SOUND_HERE, 11'd100);
    `CHK(ptr, 11'd5);
    wait_int(13000);
    `CHK(op, VRSC_OP_IDLE);
    `CHK(ptr, 11'd6);
    tend("play");
    run(`VRSC_CODE_CAPTURE_AT, 11'd2047);
    run(`VRSC_CODE_CAPTURE_HERE, 11'h000);
    `CHK(op, VRSC_OP_REC);
    wait_int(13000);
    `CHK(op, VRSC_OP_IDLE);
    tend("overflow");
    run(`VRSC_CODE_HALT_SLEEP, 11'h000);
    `CHK(ready, 1'b0);
    run(`VRSC_CODE_SKIP_AT, 11'h000);
    `CHK(op, VRSC_OP_IDLE);
    tend("sleep");
    summarize();
  end

  // a hang counts as a mismatch
  initial
  begin
    #800000;
    failures++;
    summarize();
  end
endmodule

// *** tb/vrsc_spi_sva.sv ***
`timescale 1ns/1ns
module vrsc_spi_sva (
  input wire logic clk_sys_in,
  input wire logic srst_in,
  input wire logic sclk,
  input wire logic ss_n,
  input wire logic mosi,
  input wire logic miso_o,
  input wire logic miso_oe,
  input wire logic int_o,
  input wire logic int_oe,
  input wire logic row_address_clock,
  input wire logic miso,
  input wire logic int_n
);
  // ****************************************
  // helper logic
  // ****************************************
  logic sclk_d_reg;
  logic [4:0] rise_cnt_reg;

  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (srst_in);

  // previous serial clock level, for edge finding
  always_ff @(posedge clk_sys_in)
  begin
    sclk_d_reg <= srst_in ? 1'b0 : sclk;
  end

  // rising edges within one frame; cleared while deselected
  always_ff @(posedge clk_sys_in)
  begin
    if (srst_in || ss_n)
      rise_cnt_reg <= 5'd0;
    else if (sclk && !sclk_d_reg)
      rise_cnt_reg <= rise_cnt_reg + 5'd1;
  end

  // ****************************************
  // properties
  // ****************************************
  AST_SCLK_IDLE: assert property (ss_n |-> !sclk)
    else $error("serial clock high outside a frame");
  AST_MOSI_CHANGE: assert property ($changed(mosi) && !ss_n |-> !sclk)
    else $error("host data changed while serial clock high");
  AST_MISO_HOLD: assert property (sclk && $past(sclk) && !ss_n |-> $stable(miso))
    else $error("device data changed while serial clock high");
  AST_BIT_COUNT: assert property ($rose(ss_n) |-> rise_cnt_reg == 5'd16)
    else $error("frame did not carry sixteen bits");
  AST_MISO_RELEASE: assert property (ss_n [*4] |-> !miso_oe && miso)
    else $error("data line driven while deselected");
  AST_MISO_DRIVE: assert property (miso_oe |-> miso == miso_o)
    else $error("resolved data line differs from device bit");
  AST_INT_LOW: assert property (int_oe |-> !int_o && !int_n)
    else $error("interrupt request not pulling low");
  AST_INT_CLEAR: assert property ($fell(ss_n) |-> ##[1:8] !int_oe)
    else $error("interrupt not cleared by new transfer");
  AST_INT_STANDS: assert property (int_oe && ss_n |=> int_oe)
    else $error("interrupt dropped without a transfer");
  AST_SS_GAP: assert property ($rose(ss_n) |-> ss_n [*4])
    else $error("select gap between words too short");

  // main scenarios seen
  cover property ($fell(int_n));
  cover property ($rose(ss_n) && rise_cnt_reg == 5'd16);
  cover property ($fell(row_address_clock));
endmodule
